// *** logic/hcc_compare_unit.sv ***
// Fast counters with reset-on-match, zone and output table compares.
// Assumes an APB master on pclk and raw pins from pulse sources.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module hcc_compare_unit
  import hcc_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            ce,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [AW-1:0]   paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NCNT-1:0] pulse_a,
  input  wire logic [NCNT-1:0] pulse_b,
  input  wire logic [NCNT-1:0] start_in,
  input  wire logic [NCNT-1:0] clear_in,
  output logic      [NCNT-1:0] contact,
  output logic      [NCNT-1:0] dir_flag,
  output logic      [OUTW-1:0] out_bits
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Register state.
  hcc_slot_t   slot_q [NSLOT];
  logic [31:0] lo_q   [NSLOT];
  logic [31:0] hi_q   [NSLOT];
  hcc_cctl_t   cctl_q [NCNT];
  logic [31:0] cnt_q  [NCNT];
  logic [31:0] pre_q  [NCNT];
  logic        chg_q  [NCNT];
  logic        cont_q [NCNT];
  logic        dir_q  [NCNT];
  logic [3:0]  s1_q   [NCNT];
  logic [3:0]  s2_q   [NCNT];
  logic [3:0]  s3_q   [NCNT];
  logic [3:0]  f_q    [NCNT];
  logic [15:0] tbl_q  [4*TDEP];
  logic [6:0]  idx_q;
  logic [7:0]  tcnt_q;
  logic        wrap_q;
  logic        freq_q;
  hcc_own_t    own_q;
  hcc_own_t    own_d;
  logic [OUTW-1:0] out_q;
  logic [OUTW-1:0] out_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [NCNT-1:0] rom_clr;
  logic [2:0]  tsel;
  logic        tbl_req;

  // APB decode.
  wire          acc   = psel & penable;
  wire          wr    = acc & pwrite;
  wire          setup = psel & ~penable;
  wire [AW-1:0] so    = paddr - A_SLOT;
  wire [AW-1:0] co    = paddr - A_CNT;
  wire [AW-1:0] toff  = paddr - A_TBL;
  wire [2:0]    si    = so[6:4];
  wire [4:0]    ci    = co[8:4];
  wire [1:0]    fld   = paddr[3:2];
  wire [TW-1:0] wi    = toff[TW+1:2];
  wire in_glb  = (paddr < A_GEND);
  wire in_slot = (paddr >= A_SLOT) && (so[AW-1:4] < 9'(NSLOT))
                 && (fld != F_STAT);
  wire in_cnt  = (paddr >= A_CNT) && (co[AW-1:4] < 9'(NCNT));
  wire in_tbl  = (paddr >= A_TBL) && (toff[AW-1:2] < 11'(4*TDEP));
  wire mapped  = (in_glb | in_slot | in_cnt | in_tbl)
                 && (paddr[1:0] == 2'b00);
  wire wr_ctrl = wr && in_glb && (paddr[4:2] == G_CTRL);
  wire wr_tcnt = wr && in_glb && (paddr[4:2] == G_TCNT);
  wire tcnt_ok = (pwdata[7:0] != 8'h00) && (pwdata[7:0] <= TCNT_MAX);

  // Current table record fields.
  wire [15:0] rec_hi  = tbl_q[{idx_q, 2'd0}];
  wire [15:0] rec_lo  = tbl_q[{idx_q, 2'd1}];
  wire [15:0] rec_pnw = tbl_q[{idx_q, 2'd2}];
  wire [15:0] rec_stw = tbl_q[{idx_q, 2'd3}];
  wire [31:0] rec_val = {rec_hi, rec_lo};
  wire [OAW-1:0] rec_pin = rec_pnw[OAW-1:0];
  wire        rec_st  = rec_stw[0];
  wire        last    = ({1'b0, idx_q} + 8'h01) >= tcnt_q;

  // Per-slot compare results, packed for the evaluation loop.
  wire [NSLOT-1:0] hit_v;
  wire [NSLOT-1:0] eq_v;
  wire [NSLOT-1:0] lt_v;
  wire [NSLOT-1:0] gt_v;
  wire [NSLOT-1:0] teq_v;

  // Counters with their pin synchronisers and registers.
  for (genvar c = 0; c < NCNT; c++) begin : g_cnt
    wire [3:0] pin = {clear_in[c], start_in[c], pulse_b[c], pulse_a[c]};
    wire [3:0] f_d = (s2_q[c] & s3_q[c]) | (f_q[c] & (s2_q[c] | s3_q[c]));
    wire [3:0] rise = f_d & ~f_q[c];
    wire hcc_kind_t k = cctl_q[c].kind;
    wire sd   = cctl_q[c].soft_dir;
    wire run  = cctl_q[c].drive & f_d[2];
    wire clr  = cctl_q[c].drive & f_d[3];
    wire up   = run & rise[0] & ((k == K_UPDN)
                | ((k == K_SINGLE) & ~sd)
                | ((k == K_PHASE) & ~f_d[1]));
    wire dn   = run & (((k == K_UPDN) & rise[1])
                | (rise[0] & (((k == K_SINGLE) & sd)
                | ((k == K_PHASE) & f_d[1]))));
    wire sel  = wr && in_cnt && (ci == 5'(c));
    wire wcnt = sel && (fld == F_CNT);

    // Three-stage synchroniser and agreement filter.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q[c] <= '0;
        s2_q[c] <= '0;
        s3_q[c] <= '0;
        f_q[c]  <= '0;
      end else if (ce) begin
        s1_q[c] <= pin;
        s2_q[c] <= s1_q[c];
        s3_q[c] <= s2_q[c];
        f_q[c]  <= f_d;
      end
    end

    // Control and preset words.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cctl_q[c] <= '0;
        pre_q[c]  <= PRESET_RST;
      end else if (ce) begin
        if (sel && fld == F_CTL) cctl_q[c] <= hcc_cctl_t'(pwdata[CCTLW-1:0]);
        if (sel && fld == F_PRE) pre_q[c] <= pwdata;
      end
    end

    // Count, contact, direction and pulse-change flag.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q[c]  <= '0;
        cont_q[c] <= 1'b0;
        dir_q[c]  <= 1'b0;
        chg_q[c]  <= 1'b0;
      end else if (ce) begin
        chg_q[c] <= (up | dn) & ~clr & ~wcnt;
        if (clr) begin
          cnt_q[c]  <= '0;
          cont_q[c] <= 1'b0;
        end else if (wcnt) begin
          cnt_q[c] <= pwdata;
        end else if (up | dn) begin
          cnt_q[c] <= up ? cnt_q[c] + 32'h0000_0001
                         : cnt_q[c] - 32'h0000_0001;
          dir_q[c] <= (k == K_PHASE) ? up : dn;
          if (up && cnt_q[c] == pre_q[c] - 32'h0000_0001)
            cont_q[c] <= 1'b1;
          else if (dn && cnt_q[c] == pre_q[c] + 32'h0000_0001)
            cont_q[c] <= 1'b0;
          else if (rom_clr[c])
            cont_q[c] <= 1'b0;
        end else if (rom_clr[c]) begin
          cont_q[c] <= 1'b0;
        end
      end
    end

    assign contact[c]  = cont_q[c];
    assign dir_flag[c] = dir_q[c];

    property p_hold;
      !ce || (!run && !clr && !wcnt) |=> $stable(cnt_q[c]);
    endproperty
    a_hold: assert property (p_hold)
      else $error("Counter moved without drive and start.");

    property p_clear;
      ce && clr |=> cnt_q[c] == 32'h0000_0000 && !cont_q[c];
    endproperty
    a_clear: assert property (p_clear)
      else $error("Clear input did not zero the counter.");

    property p_contact;
      ce && up && !clr && !wcnt
        && cnt_q[c] == pre_q[c] - 32'h0000_0001 |=> cont_q[c];
    endproperty
    a_contact: assert property (p_contact)
      else $error("Contact not set on reaching the preset.");

    sequence s_down;
      ce && dn && !clr && !wcnt && k == K_UPDN;
    endsequence
    property p_dir;
      s_down |=> dir_q[c] ##1 (dir_q[c] || $changed(cnt_q[c]));
    endproperty
    a_dir: assert property (p_dir)
      else $error("Direction flag not set when counting down.");

    property p_nochg;
      ce && wcnt |=> !chg_q[c];
    endproperty
    a_nochg: assert property (p_nochg)
      else $error("Written count flagged as pulse change.");
  end

  // Per-slot compare against the selected counter.
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    wire [4:0] cs = slot_q[s].cnt;
    wire ok = slot_q[s].en && (cs < 5'(NCNT));
    wire signed [31:0] v = ok ? cnt_q[cs] : 32'h0000_0000;
    assign hit_v[s] = ok && chg_q[cs];
    assign eq_v[s]  = v == $signed(lo_q[s]);
    assign lt_v[s]  = v <  $signed(lo_q[s]);
    assign gt_v[s]  = v >  $signed(hi_q[s]);
    assign teq_v[s] = v == $signed(rec_val);
  end

  // Table ownership and the lowest enabled table slot.
  always_comb begin
    tsel    = 3'h0;
    tbl_req = 1'b0;
    for (int s = NSLOT - 1; s >= 0; s--) begin
      if (slot_q[s].en && slot_q[s].mode == M_TABLE) begin
        tsel    = 3'(s);
        tbl_req = 1'b1;
      end
    end
  end

  wire tbl_hit = (own_q == OWN_OUT) && hit_v[tsel]
                 && teq_v[tsel];

  // Owner of the single table engine; the first to request keeps it.
  always_comb begin
    own_d = own_q;
    unique case (own_q)
      OWN_NONE: begin
        if (tbl_req)     own_d = OWN_OUT;
        else if (freq_q) own_d = OWN_FREQ;
      end
      OWN_OUT:  if (!tbl_req) own_d = OWN_NONE;
      OWN_FREQ: if (!freq_q)  own_d = OWN_NONE;
      default:  own_d = OWN_NONE;
    endcase
  end

  // Output and contact actions of all slots; later slots win, and a table record match wins over all.
  always_comb begin
    logic [6:0] t7;
    t7      = '0;
    out_d   = out_q;
    rom_clr = '0;
    for (int s = 0; s < NSLOT; s++) begin
      if (hit_v[s] && slot_q[s].mode == M_RESET && eq_v[s]) begin
        if (slot_q[s].to_cnt)
          rom_clr[slot_q[s].cnt] = 1'b1;
        else
          out_d[slot_q[s].tgt] = 1'b0;
      end
      if (hit_v[s] && slot_q[s].mode == M_ZONE) begin
        for (int k = 0; k < 3; k++) begin
          t7 = {1'b0, slot_q[s].tgt} + 7'(k);
          if (t7 < 7'(OUTW))
            out_d[t7[OAW-1:0]] = (k == 0) ? lt_v[s]
                               : (k == 1) ? !lt_v[s] && !gt_v[s]
                               : gt_v[s];
        end
      end
    end
    if (tbl_hit) out_d[rec_pin] = rec_st;
  end

  // Global state: outputs, table walk, owner and wrap flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q  <= '0;
      idx_q  <= '0;
      wrap_q <= 1'b0;
      own_q  <= OWN_NONE;
      freq_q <= 1'b0;
      tcnt_q <= TCNT_RST;
    end else if (ce) begin
      out_q <= out_d;
      own_q <= own_d;
      if (wr_ctrl) freq_q <= pwdata[CTRL_FREQ];
      if (wr_tcnt && tcnt_ok) tcnt_q <= pwdata[7:0];
      if (own_q != OWN_OUT) idx_q <= '0;
      else if (tbl_hit) idx_q <= last ? 7'h00 : idx_q + 7'h01;
      wrap_q <= (tbl_hit & last)
                | (wrap_q & ~(wr_ctrl & pwdata[CTRL_WRAP]));
    end
  end

  // Slot configuration and thresholds.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < NSLOT; s++) begin
        slot_q[s] <= '0;
        lo_q[s]   <= '0;
        hi_q[s]   <= '0;
      end
    end else if (ce && wr && in_slot) begin
      unique case (fld)
        F_CFG:   slot_q[si] <= hcc_slot_t'(pwdata[SLOTW-1:0]);
        F_LO:    lo_q[si]   <= pwdata;
        default: hi_q[si]   <= pwdata;
      endcase
    end
  end

  // Table record storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4*TDEP; i++) tbl_q[i] <= '0;
    end else if (ce && wr && in_tbl) begin
      tbl_q[wi] <= pwdata[15:0];
    end
  end

  // Read data selection.
  always_comb begin
    rd_d = '0;
    if (in_glb) begin
      case (paddr[4:2])
        G_CTRL: rd_d = {27'h0, freq_q, 1'b0, own_q, wrap_q};
        G_TCNT: rd_d = {24'h0, tcnt_q};
        G_TIDX: rd_d = {25'h0, idx_q};
        G_CURH: rd_d = {16'h0, rec_hi};
        G_CURL: rd_d = {16'h0, rec_lo};
        G_OUTL: rd_d = out_q[31:0];
        G_OUTH: rd_d = out_q[63:32];
        default: rd_d = '0;
      endcase
    end else if (in_slot) begin
      case (fld)
        F_CFG:   rd_d = 32'(slot_q[si]);
        F_LO:    rd_d = lo_q[si];
        default: rd_d = hi_q[si];
      endcase
    end else if (in_cnt) begin
      case (fld)
        F_CTL:   rd_d = 32'(cctl_q[ci]);
        F_CNT:   rd_d = cnt_q[ci];
        F_PRE:   rd_d = pre_q[ci];
        default: rd_d = {30'h0, dir_q[ci], cont_q[ci]};
      endcase
    end else if (in_tbl) begin
      rd_d = {16'h0, tbl_q[wi]};
    end
  end

  // Read data is sampled in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_q <= '0;
    else if (ce && setup) rd_q <= mapped ? rd_d : 32'h0000_0000;
  end

  assign prdata   = rd_q;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign out_bits = out_q;

  property p_rom;
    ce && hit_v[0] && slot_q[0].mode == M_RESET && eq_v[0]
      && !slot_q[0].to_cnt && !tbl_hit |=> !out_q[slot_q[0].tgt];
  endproperty
  a_rom: assert property (p_rom)
    else $error("Reset-on-match target not cleared.");

  property p_zone;
    ce && hit_v[NSLOT-1] && slot_q[NSLOT-1].mode == M_ZONE
      && !lt_v[NSLOT-1] && !gt_v[NSLOT-1] && !tbl_hit
      && slot_q[NSLOT-1].tgt < 6'h3E
      |=> out_q[$past(slot_q[NSLOT-1].tgt) + 6'h01]
          && !out_q[$past(slot_q[NSLOT-1].tgt)];
  endproperty
  a_zone: assert property (p_zone)
    else $error("Zone middle bit not set alone.");

  property p_rec;
    ce && tbl_hit |=> out_q[$past(rec_pin)] == $past(rec_st);
  endproperty
  a_rec: assert property (p_rec)
    else $error("Record output not driven on match.");

  property p_wrap;
    ce && tbl_hit && last |=> wrap_q && idx_q == 7'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Table did not wrap with flag.");

  property p_tcnt;
    tcnt_q != 8'h00 && tcnt_q <= TCNT_MAX;
  endproperty
  a_tcnt: assert property (p_tcnt)
    else $error("Record count out of range.");

endmodule // hcc_compare_unit

// *** logic/hcc_pkg.sv ***
// Shared constants and types of the fast counter compare unit.
// Assumes one 50 MHz clock and a 32-bit APB slave port.
package hcc_pkg;

  // Sizes of the unit.
  localparam int NCNT  = 20;            // Fast counters.
  localparam int NSLOT = 6;             // Compare functions live at once.
  localparam int TDEP  = 128;           // Table records at most.
  localparam int OUTW  = 64;            // Immediate output bits.
  localparam int OAW   = $clog2(OUTW);
  localparam int TW    = $clog2(4*TDEP);
  localparam int AW    = 13;

  // Reset values and the record count limit.
  localparam logic [31:0] PRESET_RST = 32'h0000_03E8;
  localparam logic [7:0]  TCNT_RST   = 8'h01;
  localparam logic [7:0]  TCNT_MAX   = 8'h80;

  // Byte addresses.
  localparam logic [AW-1:0] A_CTRL = 13'h0000;
  localparam logic [AW-1:0] A_GEND = 13'h001C;
  localparam logic [AW-1:0] A_SLOT = 13'h0040;
  localparam logic [AW-1:0] A_CNT  = 13'h0200;
  localparam logic [AW-1:0] A_TBL  = 13'h1000;

  // Word index inside the global group.
  localparam logic [2:0] G_CTRL = 3'h0;
  localparam logic [2:0] G_TCNT = 3'h1;
  localparam logic [2:0] G_TIDX = 3'h2;
  localparam logic [2:0] G_CURH = 3'h3;
  localparam logic [2:0] G_CURL = 3'h4;
  localparam logic [2:0] G_OUTL = 3'h5;
  localparam logic [2:0] G_OUTH = 3'h6;

  // Word index inside a slot or counter group.
  localparam logic [1:0] F_CFG  = 2'h0;
  localparam logic [1:0] F_LO   = 2'h1;
  localparam logic [1:0] F_HI   = 2'h2;
  localparam logic [1:0] F_CTL  = 2'h0;
  localparam logic [1:0] F_CNT  = 2'h1;
  localparam logic [1:0] F_PRE  = 2'h2;
  localparam logic [1:0] F_STAT = 2'h3;

  // Bits of the control word.
  localparam int CTRL_WRAP = 0;
  localparam int CTRL_FREQ = 4;

  typedef enum logic [1:0] {M_RESET, M_ZONE, M_TABLE} hcc_mode_t;
  typedef enum logic [1:0] {K_SINGLE, K_UPDN, K_PHASE} hcc_kind_t;
  typedef enum logic [1:0] {OWN_NONE, OWN_OUT, OWN_FREQ} hcc_own_t;

  typedef struct packed {
    logic [OAW-1:0] tgt;
    logic           to_cnt;
    logic [4:0]     cnt;
    hcc_mode_t      mode;
    logic           en;
  } hcc_slot_t;

  typedef struct packed {
    logic      soft_dir;
    hcc_kind_t kind;
    logic      drive;
  } hcc_cctl_t;

  localparam int SLOTW = $bits(hcc_slot_t);
  localparam int CCTLW = $bits(hcc_cctl_t);

endpackage

// *** test/hcc_pulse_src.sv ***
// Pulse source model for the encoders and switches at the counter pins.
// Assumes its task is called by the bench just after a rising clock edge.
`timescale 1ns/1ps
module hcc_pulse_src
  import hcc_pkg::*;
(
  input  wire logic            pclk,
  output logic      [NCNT-1:0] pulse_a,
  output logic      [NCNT-1:0] pulse_b
);
  // Both lines rest low between pulses.
  initial begin
    pulse_a = '0;
    pulse_b = '0;
  end

  // One pulse on line A or B, four cycles high and four low, so the
  // pin synchronisers always see both levels.
  task automatic pulse(input int c, input bit on_b);
    @(posedge pclk);
    pulse_a[c] <= !on_b;
    pulse_b[c] <= on_b;
    repeat (4) @(posedge pclk);
    pulse_a[c] <= 1'b0;
    pulse_b[c] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // One two-phase step: the leading line rises, the other follows four
  // cycles later, and both fall again in the same order.
  task automatic quad(input int c, input bit a_lead);
    @(posedge pclk);
    if (a_lead) pulse_a[c] <= 1'b1;
    else pulse_b[c] <= 1'b1;
    repeat (4) @(posedge pclk);
    if (a_lead) pulse_b[c] <= 1'b1;
    else pulse_a[c] <= 1'b1;
    repeat (4) @(posedge pclk);
    if (a_lead) pulse_a[c] <= 1'b0;
    else pulse_b[c] <= 1'b0;
    repeat (4) @(posedge pclk);
    pulse_a[c] <= 1'b0;
    pulse_b[c] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule // hcc_pulse_src

// *** test/hs_counter_compare_unit_bench.sv ***
// Self-checking bench of the fast counter compare unit.
// Assumes the pulse source model and a 50 MHz clock on pclk.
`timescale 1ns/1ps
module hs_counter_compare_unit_bench
  import hcc_pkg::*;
;
  logic            pclk;
  logic            presetn;
  logic            ce;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [AW-1:0]   paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [NCNT-1:0] pulse_a;
  logic [NCNT-1:0] pulse_b;
  logic [NCNT-1:0] start_in;
  logic [NCNT-1:0] clear_in;
  logic [NCNT-1:0] contact;
  logic [NCNT-1:0] dir_flag;
  logic [OUTW-1:0] out_bits;
  logic [31:0]     rd_q;
  logic            err_q;
  int              errors;
  int              checks;

  // The unit under test and the pulse sources at its pins.
  hcc_compare_unit hcc_compare_unit_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulse_a(pulse_a), .pulse_b(pulse_b), .start_in(start_in),
    .clear_in(clear_in), .contact(contact), .dir_flag(dir_flag),
    .out_bits(out_bits)
  );
  hcc_pulse_src hcc_pulse_src_i (
    .pclk(pclk), .pulse_a(pulse_a), .pulse_b(pulse_b)
  );

  // Free-running clock of 20 ns.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high.
  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Reads a word and compares it with the expected value.
  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_q, e);
  endtask

  // Address helpers for counter, slot and global words.
  function automatic logic [AW-1:0] ca(input int c, input int f);
    return AW'(A_CNT + 16*c + 4*f);
  endfunction
  function automatic logic [AW-1:0] sa(input int s, input int f);
    return AW'(A_SLOT + 16*s + 4*f);
  endfunction
  function automatic logic [AW-1:0] ga(input int g);
    return AW'(A_CTRL + 4*g);
  endfunction
  function automatic logic [31:0] cfg(input int t, input logic to_c,
                                      input hcc_mode_t m);
    hcc_slot_t s;
    s = '{tgt: OAW'(t), to_cnt: to_c, cnt: 5'h00, mode: m, en: 1'b1};
    return 32'(s);
  endfunction

  task automatic pls(input int c, input bit b, input int n);
    repeat (n) hcc_pulse_src_i.pulse(c, b);
  endtask

  // Reset values and an address past the last slot.
  task automatic t_reset();
    rdc(ca(0, F_PRE), PRESET_RST);
    rdc(ga(G_TCNT), 32'(TCNT_RST));
    rdc(sa(NSLOT, F_CFG), 32'h0000_0000);
    chk(32'(err_q), 32'h0000_0001);
  endtask

  // Drive, start, contact on the way up and soft direction down.
  task automatic t_count();
    pls(0, 1'b0, 1);
    rdc(ca(0, F_CNT), 32'h0000_0000);
    wr(ca(0, F_CTL), 32'h0000_0001);
    start_in[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    pls(0, 1'b0, 1);
    rdc(ca(0, F_CNT), 32'h0000_0000);
    start_in[0] <= 1'b1;
    wr(ca(0, F_CNT), 32'h0000_03E6);
    pls(0, 1'b0, 2);
    chk(32'(contact[0]), 32'h0000_0001);
    pls(0, 1'b0, 1);
    wr(ca(0, F_CTL), 32'h0000_0009);
    pls(0, 1'b0, 1);
    chk(32'(contact[0]), 32'h0000_0000);
    rdc(ca(0, F_CNT), 32'h0000_03E8);
    wr(ca(0, F_CTL), 32'h0000_0001);
  endtask

  // Reset-on-match clears the contact of the compared counter.
  task automatic t_match();
    wr(ca(0, F_CNT), 32'h0000_03E7);
    pls(0, 1'b0, 1);
    wr(sa(0, F_LO), 32'h0000_03EA);
    wr(sa(0, F_CFG), cfg(0, 1'b1, M_RESET));
    pls(0, 1'b0, 1);
    chk(32'(contact[0]), 32'h0000_0001);
    pls(0, 1'b0, 1);
    chk(32'(contact[0]), 32'h0000_0000);
    wr(sa(0, F_CFG), 32'h0000_0000);
  endtask

  // Zone walk across signed bounds, a written count, then a pin reset.
  task automatic t_zone();
    logic [31:0] e;
    wr(sa(NSLOT-1, F_LO), 32'hFFFF_FFFE);
    wr(sa(NSLOT-1, F_HI), 32'h0000_0001);
    wr(ca(0, F_CNT), 32'hFFFF_FFFC);
    wr(sa(NSLOT-1, F_CFG), cfg(8, 1'b0, M_ZONE));
    for (int v = -3; v <= 2; v++) begin
      pls(0, 1'b0, 1);
      e = (v < -2) ? 1 : (v <= 1) ? 2 : 4;
      chk(32'(out_bits[10:8]), e);
    end
    wr(ca(0, F_CNT), 32'hFFFF_FFF0);
    repeat (4) @(posedge pclk);
    chk(32'(out_bits[10:8]), 32'h0000_0004);
    wr(sa(NSLOT-1, F_CFG), 32'h0000_0000);
    wr(sa(0, F_LO), 32'hFFFF_FFF1);
    wr(sa(0, F_CFG), cfg(10, 1'b0, M_RESET));
    pls(0, 1'b0, 1);
    chk(32'(out_bits[10:8]), 32'h0000_0000);
    wr(sa(0, F_CFG), 32'h0000_0000);
  endtask

  // Clear input zeroes count and contact.
  task automatic t_clear();
    wr(ca(0, F_CNT), 32'h0000_03E7);
    pls(0, 1'b0, 1);
    clear_in[0] <= 1'b1;
    repeat (6) @(posedge pclk);
    clear_in[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(contact[0]), 32'h0000_0000);
    rdc(ca(0, F_CNT), 32'h0000_0000);
  endtask

  // Two-record table: match, step, wrap, status and ownership.
  task automatic t_table();
    logic [31:0] tb [8];
    tb = '{32'h0000_0000, 32'h0000_0003, 32'h0000_0014, 32'h0000_0001,
           32'h0000_0000, 32'h0000_0005, 32'h0000_0014, 32'h0000_0000};
    for (int w = 0; w < 8; w++) begin
      wr(AW'(A_TBL + 4*w), tb[w]);
    end
    wr(ga(G_TCNT), 32'h0000_0002);
    wr(sa(2, F_CFG), cfg(0, 1'b0, M_TABLE));
    rdc(ga(G_TIDX), 32'h0000_0000);
    rdc(ga(G_CURL), 32'h0000_0003);
    pls(0, 1'b0, 3);
    chk(32'(out_bits[20]), 32'h0000_0001);
    rdc(ga(G_OUTL), 32'h0010_0000);
    rdc(ga(G_TIDX), 32'h0000_0001);
    rdc(ga(G_CURH), 32'h0000_0000);
    rdc(ga(G_CURL), 32'h0000_0005);
    pls(0, 1'b0, 2);
    chk(32'(out_bits[20]), 32'h0000_0000);
    rdc(ga(G_TIDX), 32'h0000_0000);
    rdc(ga(G_CTRL), 32'h0000_0003);
    wr(ga(G_CTRL), 32'h0000_0011);
    rdc(ga(G_CTRL), 32'h0000_0012);
    wr(ga(G_TCNT), 32'h0000_0000);
    rdc(ga(G_TCNT), 32'h0000_0002);
    wr(ga(G_TCNT), 32'h0000_0081);
    rdc(ga(G_TCNT), 32'h0000_0002);
    wr(ga(G_TCNT), 32'(TCNT_MAX));
    rdc(ga(G_TCNT), 32'(TCNT_MAX));
  endtask

  // Up/down counter: flag follows the input that counted.
  task automatic t_updn();
    wr(ca(1, F_CTL), 32'(hcc_cctl_t'{1'b0, K_UPDN, 1'b1}));
    pls(1, 1'b1, 1);
    chk(32'(dir_flag[1]), 32'h0000_0001);
    rdc(ca(1, F_CNT), 32'hFFFF_FFFF);
    pls(1, 1'b0, 1);
    chk(32'(dir_flag[1]), 32'h0000_0000);
    ce <= 1'b0;
    pls(1, 1'b0, 1);
    ce <= 1'b1;
    rdc(ca(1, F_CNT), 32'h0000_0000);
  endtask

  // Two-phase counter: up with flag on when line A leads, down otherwise.
  task automatic t_phase();
    wr(ca(2, F_CTL), 32'(hcc_cctl_t'{1'b0, K_PHASE, 1'b1}));
    hcc_pulse_src_i.quad(2, 1'b1);
    chk(32'(dir_flag[2]), 32'h0000_0001);
    rdc(ca(2, F_CNT), 32'h0000_0001);
    hcc_pulse_src_i.quad(2, 1'b0);
    chk(32'(dir_flag[2]), 32'h0000_0000);
    rdc(ca(2, F_CNT), 32'h0000_0000);
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence after eight cycles of reset.
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    start_in = '1;
    clear_in = '0;
    errors = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count();
    t_match();
    t_zone();
    t_clear();
    t_table();
    t_updn();
    t_phase();
    complete_run();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end
endmodule // hs_counter_compare_unit_bench
